// file: logic/flash_timing_regs.svh
// Purpose: register offsets, field positions and reset values of the flash timing block
// Assumes: included by bare name
// Notes: offsets are byte addresses
`ifndef FLASH_TIMING_REGS_SVH
`define FLASH_TIMING_REGS_SVH
`define OFF_TIMING_CTRL 8'h18
`define OFF_PROG_STATUS 8'h40
`define OFF_IRQ_STATUS 8'h44
`define OFF_IRQ_MASK 8'h48
`define OFF_PROTECT_CTRL 8'h4c
`define OFF_PROG_CTRL 8'h50
`define OFF_TRIGGER 8'h54
`define BIT_FOM_HI 6
`define BIT_FOM_LO 4
`define BIT_FAIL 6
`define BIT_CFG_UEN 4
`define VEC_LSB 9
`define VEC_MSB 20
`define BOOT_LSB 1
`define BOOT_MSB 2
`define BIT_GO 0
`define IRQ_FAIL 0
`define IRQ_DONE 1
`define IRQ_W 2
`define RESET_WORD 32'h0000_0000
`define VEC_PAGE_BITS 9
`define LOCAL_MASK 16'h01ff
`define UNLOCK_1 8'h59
`define UNLOCK_2 8'h16
`define UNLOCK_3 8'h88
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define FOM_SEQ50 2'b00
`define FOM_RAND25 2'b01
`endif

// file: logic/flash_timing_pkg.sv
// Purpose: types shared by the flash timing block
// Assumes: nothing
// Notes: none
package flash_timing_pkg;
  typedef enum logic [1:0] {
    REGION_APP = 2'b00,
    REGION_LOADER = 2'b01,
    REGION_CONFIG = 2'b10,
    REGION_ILLEGAL = 2'b11
  } region_type;
  typedef enum logic [1:0] {
    ULK_IDLE = 2'b00,
    ULK_GOT1 = 2'b01,
    ULK_GOT2 = 2'b10,
    ULK_OPEN = 2'b11
  } unlock_type;
endpackage : flash_timing_pkg

// file: logic/op_check_if.sv
// Purpose: carries a started flash operation to the legality checker
// Assumes: one clock
// Notes: combinational answer
`timescale 1ns/1ps
interface op_check_if;
  logic [1:0] srcRegion;
  logic [1:0] dstRegion;
  logic isWrite;
  logic cfgUpdateEnable;
  logic fail;
  modport ctrl (output srcRegion, output dstRegion, output isWrite, output cfgUpdateEnable,
    input fail);
  modport chk (input srcRegion, input dstRegion, input isWrite, input cfgUpdateEnable,
    output fail);
endinterface : op_check_if

// file: logic/op_checker.sv
// Purpose: decides whether a triggered flash operation is illegal
// Assumes: region codes from the controller
// Notes: combinational
`timescale 1ns/1ps
module op_checker import flash_timing_pkg::*; (
  op_check_if.chk chk
);
  always_comb begin
    chk.fail = 1'b0;
    if (chk.dstRegion == REGION_ILLEGAL) begin
      chk.fail = 1'b1;
    end else if (chk.isWrite && chk.srcRegion == chk.dstRegion &&
                 chk.dstRegion != REGION_CONFIG) begin
      chk.fail = 1'b1;
    end else if (chk.isWrite && chk.dstRegion == REGION_CONFIG && !chk.cfgUpdateEnable) begin
      chk.fail = 1'b1;
    end
  end
endmodule : op_checker

// file: logic/flash_timing_ctrl.sv
// Purpose: flash access timing select and programming status registers over AXI4-Lite
// Assumes: single clock, synchronous active-low reset, one access of each kind at a time
// Notes: flash array side seen through plain ports
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "flash_timing_regs.svh"
module flash_timing_ctrl import flash_timing_pkg::*; #(
  parameter int VEC_W = 12
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [1:0] bootSelect,
  input wire logic [VEC_W-1:0] vectorPageBase,
  input wire logic [1:0] srcRegion,
  input wire logic [1:0] dstRegion,
  input wire logic isWrite,
  input wire logic opDone,
  input wire logic [15:0] cpuAddr,
  output logic [VEC_W+8:0] flashAddr,
  output logic opStart,
  output logic [1:0] freqOptMode,
  output logic irq
);
  logic [7:0] awAddr_q;
  logic awHave_q, wHave_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic freqOptSelectHi_q, freqOptSelectLo_q;
  logic failFlag_q, startTrigger_q, cfgUpdateEnable_q;
  logic [`IRQ_W-1:0] irqStatus_q, irqMask_q;
  unlock_type unlock_q;
  logic wrFire, failSet, doneSet, opFail, trigHit;
  logic [31:0] rdWord;
  logic rdOk, wrOk;
  op_check_if chkBus ();

  function automatic logic known(input logic [7:0] a);
    known = a == `OFF_TIMING_CTRL || a == `OFF_PROG_STATUS || a == `OFF_IRQ_STATUS ||
      a == `OFF_IRQ_MASK || a == `OFF_PROTECT_CTRL || a == `OFF_PROG_CTRL ||
      a == `OFF_TRIGGER;
  endfunction : known

  assign chkBus.srcRegion = srcRegion;
  assign chkBus.dstRegion = dstRegion;
  assign chkBus.isWrite = isWrite;
  assign chkBus.cfgUpdateEnable = cfgUpdateEnable_q;
  assign opFail = chkBus.fail;

  op_checker opCheck (
    .chk(chkBus.chk)
  );

  // write channel capture, either order
  assign awready = !awHave_q;
  assign wready = !wHave_q;
  assign wrFire = awHave_q && wHave_q && !bvalid;
  assign wrOk = known(awAddr_q);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= `RESET_WORD;
      wStrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (wrFire) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // unlock sequence; any other byte to the protection register relocks
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      unlock_q <= ULK_IDLE;
    end else if (wrFire && awAddr_q == `OFF_PROTECT_CTRL && wStrb_q[0]) begin
      unique case (unlock_q)
        ULK_IDLE: unlock_q <= wData_q[7:0] == `UNLOCK_1 ? ULK_GOT1 : ULK_IDLE;
        ULK_GOT1: unlock_q <= wData_q[7:0] == `UNLOCK_2 ? ULK_GOT2 : ULK_IDLE;
        ULK_GOT2: unlock_q <= wData_q[7:0] == `UNLOCK_3 ? ULK_OPEN : ULK_IDLE;
        ULK_OPEN: unlock_q <= ULK_IDLE;
      endcase
    end
  end

  // timing select, protected
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      freqOptSelectHi_q <= 1'b0;
      freqOptSelectLo_q <= 1'b0;
    end else if (wrFire && awAddr_q == `OFF_TIMING_CTRL && wStrb_q[0] &&
                 unlock_q == ULK_OPEN) begin
      freqOptSelectHi_q <= wData_q[`BIT_FOM_HI];
      freqOptSelectLo_q <= wData_q[`BIT_FOM_LO];
    end
  end
  assign freqOptMode = {freqOptSelectHi_q, freqOptSelectLo_q};

  // config update enable in the control register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfgUpdateEnable_q <= 1'b0;
    end else if (wrFire && awAddr_q == `OFF_PROG_CTRL && wStrb_q[0] && unlock_q == ULK_OPEN) begin
      cfgUpdateEnable_q <= wData_q[`BIT_CFG_UEN];
    end
  end

  // start trigger: set by protected write, cleared when the operation completes
  // an illegal operation is refused here, so it never reaches the array and a
  // running operation never depends on region inputs after its start
  assign trigHit = wrFire && awAddr_q == `OFF_TRIGGER && wStrb_q[0] && wData_q[`BIT_GO] &&
    unlock_q == ULK_OPEN && !startTrigger_q;
  assign opStart = trigHit && !opFail;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      startTrigger_q <= 1'b0;
    end else if (opStart) begin
      startTrigger_q <= 1'b1;
    end else if (opDone) begin
      startTrigger_q <= 1'b0;
    end
  end

  // fail flag, shared by status and control registers; set wins over clear
  assign failSet = trigHit && opFail;
  assign doneSet = (startTrigger_q && opDone) || failSet;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      failFlag_q <= 1'b0;
    end else if (failSet) begin
      failFlag_q <= 1'b1;
    end else if (wrFire && (awAddr_q == `OFF_PROG_STATUS || awAddr_q == `OFF_PROG_CTRL) &&
                 wStrb_q[0] && wData_q[`BIT_FAIL] && unlock_q == ULK_OPEN) begin
      failFlag_q <= 1'b0;
    end
  end

  // interrupt status, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqStatus_q <= '0;
      irqMask_q <= '0;
    end else begin
      for (int i = 0; i < `IRQ_W; i++) begin
        if ((i == `IRQ_FAIL && failSet) || (i == `IRQ_DONE && doneSet)) begin
          irqStatus_q[i] <= 1'b1;
        end else if (wrFire && awAddr_q == `OFF_IRQ_STATUS && wStrb_q[0] && wData_q[i]) begin
          irqStatus_q[i] <= 1'b0;
        end
      end
      if (wrFire && awAddr_q == `OFF_IRQ_MASK && wStrb_q[0]) begin
        irqMask_q <= wData_q[`IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irqStatus_q & irqMask_q);

  // vector remap of the low page
  always_comb begin
    if ((cpuAddr & ~`LOCAL_MASK) == 16'h0000) begin
      flashAddr = {vectorPageBase, cpuAddr[`VEC_PAGE_BITS-1:0]};
    end else begin
      flashAddr = {{(VEC_W+9-16){1'b0}}, cpuAddr};
    end
  end

  // read data mux; reserved bits zero
  assign rdOk = known(araddr);
  always_comb begin
    rdWord = `RESET_WORD;
    unique case (araddr)
      `OFF_TIMING_CTRL: begin
        rdWord[`BIT_FOM_HI] = freqOptSelectHi_q;
        rdWord[`BIT_FOM_LO] = freqOptSelectLo_q;
      end
      `OFF_PROG_STATUS: begin
        rdWord[`VEC_MSB:`VEC_LSB] = vectorPageBase;
        rdWord[`BIT_FAIL] = failFlag_q;
        rdWord[`BOOT_MSB:`BOOT_LSB] = bootSelect;
        rdWord[`BIT_GO] = startTrigger_q;
      end
      `OFF_IRQ_STATUS: rdWord[`IRQ_W-1:0] = irqStatus_q;
      `OFF_IRQ_MASK: rdWord[`IRQ_W-1:0] = irqMask_q;
      `OFF_PROTECT_CTRL: rdWord[0] = unlock_q == ULK_OPEN;
      `OFF_PROG_CTRL: begin
        rdWord[`BIT_FAIL] = failFlag_q;
        rdWord[`BIT_CFG_UEN] = cfgUpdateEnable_q;
      end
      `OFF_TRIGGER: rdWord[`BIT_GO] = startTrigger_q;
      default: rdWord = `RESET_WORD;
    endcase
  end

  assign arready = !rvalid;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata <= `RESET_WORD;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rdWord;
      rresp <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // checks
  fom_protect_a: assert property (@(posedge clk) disable iff (!rst_b)
    unlock_q != ULK_OPEN |=> $stable(freqOptMode))
    else $error("timing select changed while locked");
  fail_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    trigHit && dstRegion == REGION_ILLEGAL |=> failFlag_q)
    else $error("fail flag not set on illegal destination");
  self_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    trigHit && isWrite && srcRegion == REGION_APP && dstRegion == REGION_APP |=> failFlag_q)
    else $error("fail flag not set on self write");
  cfg_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
    trigHit && isWrite && dstRegion == REGION_CONFIG && !cfgUpdateEnable_q |=> failFlag_q)
    else $error("fail flag not set on locked config write");
  trig_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    startTrigger_q && opDone && !opStart |=> !startTrigger_q)
    else $error("trigger not cleared at completion");
  fail_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    failFlag_q && !(wrFire && wData_q[`BIT_FAIL]) |=> failFlag_q)
    else $error("fail flag lost without clear");
  remap_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    cpuAddr[15:9] == 7'h00 |-> flashAddr[VEC_W+8:9] == vectorPageBase)
    else $error("low page not remapped");
  status_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    arvalid && arready && araddr == `OFF_PROG_STATUS |=>
      rvalid && rdata[`BIT_GO] == $past(startTrigger_q) &&
      rdata[`BOOT_MSB:`BOOT_LSB] == $past(bootSelect))
    else $error("status read mismatch");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    failSet && irqMask_q[`IRQ_FAIL] |=> ##1 irq)
    else $error("interrupt not raised");
  trig_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    opStart |=> startTrigger_q)
    else $error("trigger not set by accepted start");
  fail_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    wrFire && awAddr_q == `OFF_PROG_CTRL && wStrb_q[0] && wData_q[`BIT_FAIL] &&
      unlock_q == ULK_OPEN && !failSet |=> !failFlag_q)
    else $error("fail flag not cleared by write one");
  rsvd_timing_a: assert property (@(posedge clk) disable iff (!rst_b)
    arvalid && arready && araddr == `OFF_TIMING_CTRL |=>
      rdata[31:`BIT_FOM_HI+1] == '0 && rdata[`BIT_FOM_HI-1:`BIT_FOM_LO+1] == '0 &&
      rdata[`BIT_FOM_LO-1:0] == '0)
    else $error("reserved timing bits not zero");
  unlock_c: cover property (@(posedge clk) disable iff (!rst_b) unlock_q == ULK_OPEN);
  fail_c: cover property (@(posedge clk) disable iff (!rst_b) failSet);
  done_c: cover property (@(posedge clk) disable iff (!rst_b) startTrigger_q && opDone);
  mode_c: cover property (@(posedge clk) disable iff (!rst_b) freqOptMode == `FOM_RAND25);
endmodule : flash_timing_ctrl

// file: tb/flash_array_model.sv
// Purpose: stand-in for the flash array behind the timing block
// Assumes: opStart is a one-cycle pulse
// Notes: answers each started operation with opDone after DELAY cycles
`timescale 1ns/1ps
module flash_array_model #(
  parameter int DELAY = 30
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic opStart,
  output logic opDone
);
  int remain_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      remain_q <= 0;
      opDone <= 1'b0;
    end else begin
      opDone <= (remain_q == 1);
      if (opStart) begin
        remain_q <= DELAY;
      end else if (remain_q != 0) begin
        remain_q <= remain_q - 1;
      end
    end
  end
endmodule : flash_array_model

// file: tb/tb_top.sv
// Purpose: self-checking bench for the flash timing block
// Assumes: AXI4-Lite master tasks, one access at a time
// Notes: flash array model gives completion after 30 cycles
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bootSelect = 2'h0, srcRegion = 2'h0, dstRegion = 2'h0;
  logic isWrite = 1'b0;
  logic [11:0] vectorPageBase = 12'h000;
  logic [15:0] cpuAddr = 16'h0000;
  wire logic awready, wready, bvalid, arready, rvalid, opDone, opStart, irq;
  wire logic [1:0] bresp, rresp, freqOptMode;
  wire logic [31:0] rdata;
  wire logic [20:0] flashAddr;
  logic [1:0] rsp;
  int n_fail = 0;
  int n_tests = 0;

  flash_timing_ctrl uut (.clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .bootSelect, .vectorPageBase, .srcRegion, .dstRegion, .isWrite, .opDone,
    .cpuAddr, .flashAddr, .opStart, .freqOptMode, .irq);
  flash_array_model #(.DELAY(30)) array (.clk, .rst_b, .opStart, .opDone);

  always #5 clk = ~clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge clk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd_chk

  task unlock();
    wr(8'h4c, 32'h59);
    wr(8'h4c, 32'h16);
    wr(8'h4c, 32'h88);
  endtask : unlock

  task wait_done();
    int i;
    i = 0;
    while (!opDone && i < 100) begin
      @(posedge clk);
      i++;
    end
    chk({31'h0, opDone}, 32'h1);
    repeat (2) @(posedge clk);
  endtask : wait_done

  task t_timing();
    wr(8'h18, 32'h50);
    rd_chk(8'h18, 32'h0, 2'b00);
    unlock();
    wr(8'h18, 32'hffffffff);
    rd_chk(8'h18, 32'h50, 2'b00);
    chk({30'h0, freqOptMode}, 32'h3);
    wr(8'h18, 32'h10);
    chk({30'h0, freqOptMode}, 32'h1);
    wr(8'h18, 32'h0);
    chk({30'h0, freqOptMode}, 32'h0);
    wr(8'h4c, 32'h0);
    wr(8'h18, 32'h10);
    chk({30'h0, freqOptMode}, 32'h0);
    $display("test timing done");
  endtask : t_timing

  task t_mirror();
    bootSelect <= 2'h2;
    vectorPageBase <= 12'habc;
    cpuAddr <= 16'h0123;
    wr(8'h40, 32'hffffffff);
    rd_chk(8'h40, 32'h00157804, 2'b00);
    chk({11'h0, flashAddr}, 32'h00157923);
    cpuAddr <= 16'h0200;
    @(posedge clk);
    @(posedge clk);
    chk({11'h0, flashAddr}, 32'h00000200);
    bootSelect <= 2'h0;
    vectorPageBase <= 12'h000;
    rd_chk(8'h08, 32'h0, 2'b10);
    wr(8'h08, 32'h1);
    chk({30'h0, rsp}, 32'h2);
    $display("test mirror done");
  endtask : t_mirror

  task t_op();
    unlock();
    wr(8'h48, 32'h1);
    srcRegion <= 2'h0;
    dstRegion <= 2'h1;
    isWrite <= 1'b1;
    wr(8'h54, 32'h1);
    rd_chk(8'h40, 32'h1, 2'b00);
    wait_done();
    rd_chk(8'h54, 32'h0, 2'b00);
    rd_chk(8'h40, 32'h0, 2'b00);
    rd_chk(8'h44, 32'h2, 2'b00);
    chk({31'h0, irq}, 32'h0);
    wr(8'h44, 32'h3);
    $display("test operation done");
  endtask : t_op

  task t_fail();
    for (int k = 0; k < 4; k++) begin
      // self write of the app and loader areas, locked config write, illegal destination
      srcRegion <= (k == 1) ? 2'h1 : 2'h0;
      dstRegion <= k[1:0];
      wr(8'h54, 32'h1);
      rd_chk(8'h40, 32'h40, 2'b00);
      rd_chk(8'h50, 32'h40, 2'b00);
      chk({31'h0, irq}, 32'h1);
      wr(8'h40, 32'h0);
      rd_chk(8'h40, 32'h40, 2'b00);
      if (k == 0) begin
        wr(8'h4c, 32'h0);
        wr(8'h40, 32'h40);
        rd_chk(8'h40, 32'h40, 2'b00);
        unlock();
      end
      wr(k[0] ? 8'h50 : 8'h40, 32'h40);
      rd_chk(8'h40, 32'h0, 2'b00);
      wr(8'h44, 32'h3);
      chk({31'h0, irq}, 32'h0);
    end
    wr(8'h50, 32'h10);
    dstRegion <= 2'h2;
    wr(8'h54, 32'h1);
    rd_chk(8'h40, 32'h1, 2'b00);
    wait_done();
    wr(8'h50, 32'h0);
    $display("test fail flag done");
  endtask : t_fail

  task end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_timing();
    t_mirror();
    t_op();
    t_fail();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule : tb_top
